// File: logic/cmb_defs.svh
`ifndef CMB_DEFS_SVH
`define CMB_DEFS_SVH

// Register word indexes (byte address = index * 4)
`define CMB_IX_TX_ID_HIGH 6'h00
`define CMB_IX_TX_ID_LOW 6'h01
`define CMB_IX_TX_PAY0 6'h02
`define CMB_IX_TX_PAY7 6'h09
`define CMB_IX_TX_LENGTH 6'h0a
`define CMB_IX_TX_PRIO 6'h0b
`define CMB_IX_RX_ID_HIGH 6'h10
`define CMB_IX_RX_ID_LOW 6'h11
`define CMB_IX_RX_PAY0 6'h12
`define CMB_IX_RX_PAY7 6'h19
`define CMB_IX_RX_LENGTH 6'h1a
`define CMB_IX_TX_SELECT 6'h20
`define CMB_IX_TX_EMPTY 6'h21
`define CMB_IX_RX_FULL 6'h22
`define CMB_IX_TX_STATUS 6'h23

// Field positions in the low identifier byte and in the 11-bit identifier
`define CMB_ID_LOW_MSB 7
`define CMB_ID_LOW_LSB 5
`define CMB_RTR_BIT 4
`define CMB_IDE_BIT 3
`define CMB_ID_HIGH_MSB 10
`define CMB_ID_HIGH_LSB 3
`define CMB_ID_TAIL_MSB 2

// Length code field and limits
`define CMB_DLC_MSB 3
`define CMB_MAX_BYTES 4'h8
`define CMB_ZERO_BYTES 4'h0

// Reset values
`define CMB_PRIO_RESET 8'h00
`define CMB_BYTE_RESET 8'h00

`endif

// File: logic/cmb_pkg.sv
package cmb_pkg;

	typedef enum logic [1:0] {
		CMB_TX_IDLE,
		CMB_TX_HEADER,
		CMB_TX_DATA,
		CMB_TX_WAIT
	} cmb_tx_state_t;

	// One beat toward the bit engine: a header beat, then payload beats
	typedef struct packed {
		logic [10:0] ident;
		logic rtr;
		logic ide;
		logic [3:0] dlc;
		logic is_header;
		logic last;
		logic [7:0] data;
	} cmb_tx_beat_t;

	// A whole frame from the receive engine
	typedef struct packed {
		logic [10:0] ident;
		logic rtr;
		logic ide;
		logic [3:0] dlc;
		logic [63:0] data;
	} cmb_rx_frame_t;

endpackage

// File: logic/cmb_message_buffers.sv
// Added by the designer: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`include "cmb_defs.svh"

module cmb_message_buffers
	import cmb_pkg::*;
#(
	parameter int NUM_TX = 3
)
(
	// Clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Transmit side toward the bit engine
	input wire logic sof_req_i,
	input wire logic tx_done_i,
	input wire logic tx_fail_i,
	output logic tx_pending_o,
	output cmb_tx_beat_t tx_beat_o,
	output logic tx_valid_o,
	input wire logic tx_ready_i,
	// Receive side from the bit engine
	input wire cmb_rx_frame_t rx_frame_i,
	input wire logic rx_valid_i,
	output logic rx_ready_o
);

	// Transmit buffer storage
	logic [10:0] tx_ident_reg [NUM_TX];
	logic tx_rtr_reg [NUM_TX];
	logic tx_ide_reg [NUM_TX];
	logic [3:0] tx_dlc_reg [NUM_TX];
	logic [7:0] tx_prio_reg [NUM_TX];
	logic [7:0] tx_pay_reg [NUM_TX][8];
	logic [NUM_TX-1:0] tx_empty_reg;
	logic [NUM_TX-1:0] tx_select_reg;
	// Receive buffer storage
	cmb_rx_frame_t rx_buf_reg;
	logic rx_full_reg;
	// Bus
	logic ack_reg;
	logic [31:0] dat_reg;
	logic bus_req;
	logic bus_wr;
	logic [5:0] widx;
	logic sel_ok;
	logic [NUM_TX-1:0] sel_pick;
	// Transmit sequencer
	cmb_tx_state_t tx_state_reg;
	logic [$clog2(NUM_TX)-1:0] tx_active_reg;
	logic [3:0] tx_byte_reg;
	logic [3:0] tx_count;
	logic win_found;
	logic [$clog2(NUM_TX)-1:0] win_idx;
	logic [7:0] win_prio;
	// Two-entry buffer
	cmb_tx_beat_t fifo_mem_reg [2];
	logic fifo_wptr_reg;
	logic fifo_rptr_reg;
	logic [1:0] fifo_cnt_reg;
	logic fifo_in_valid;
	logic fifo_in_ready;
	cmb_tx_beat_t fifo_in;

	// Byte count sent for the active buffer
	function automatic logic [3:0] byte_count(input logic rtr, input logic [3:0] dlc);
		logic [3:0] n;
		n = (dlc > `CMB_MAX_BYTES) ? `CMB_MAX_BYTES : dlc;
		if (rtr)
			n = `CMB_ZERO_BYTES;
		return n;
	endfunction

	assign bus_req = cyc_i && stb_i && !ack_reg;
	assign bus_wr = bus_req && we_i && sel_i[0] && ce_i;
	assign widx = adr_i[7:2];
	assign ack_o = ack_reg;
	assign dat_o = dat_reg;

	// Selected buffer is open to software only while empty
	assign sel_ok = |(tx_select_reg & tx_empty_reg);

	// Selection write keeps the lowest requested buffer that is empty
	always_comb
	begin
		sel_pick = '0;
		for (int i = NUM_TX - 1; i >= 0; i--)
			if (dat_i[i] && tx_empty_reg[i])
			begin
				sel_pick = '0;
				sel_pick[i] = 1'b1;
			end
	end

	// Internal prioritisation among pending buffers
	always_comb
	begin
		win_found = 1'b0;
		win_idx = '0;
		win_prio = 8'hff;
		for (int i = 0; i < NUM_TX; i++)
			if (!tx_empty_reg[i])
			begin
				// Strict less-than keeps the earlier index on a tie
				if (!win_found || tx_prio_reg[i] < win_prio)
				begin
					win_found = 1'b1;
					win_idx = i[$clog2(NUM_TX)-1:0];
					win_prio = tx_prio_reg[i];
				end
			end
	end

	assign tx_pending_o = win_found;

	// Wishbone acknowledge, one cycle after the request
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ack_reg <= 1'b0;
		else if (ce_i)
			ack_reg <= bus_req;
	end

	// Read data mux; unmapped words read as zero
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			dat_reg <= '0;
		else if (ce_i && bus_req)
		begin
			dat_reg <= '0;
			if (!we_i)
			begin
				for (int i = 0; i < NUM_TX; i++)
				begin
					if (tx_select_reg[i] && tx_empty_reg[i])
					begin
						if (widx == `CMB_IX_TX_ID_HIGH)
							dat_reg[7:0] <= tx_ident_reg[i][`CMB_ID_HIGH_MSB:`CMB_ID_HIGH_LSB];
						if (widx == `CMB_IX_TX_ID_LOW)
							dat_reg[7:0] <= {tx_ident_reg[i][`CMB_ID_TAIL_MSB:0],
								tx_rtr_reg[i], tx_ide_reg[i], 3'h0};
						if (widx >= `CMB_IX_TX_PAY0 && widx <= `CMB_IX_TX_PAY7)
							dat_reg[7:0] <= tx_pay_reg[i][3'(widx - `CMB_IX_TX_PAY0)];
						if (widx == `CMB_IX_TX_LENGTH)
							dat_reg[7:0] <= {4'h0, tx_dlc_reg[i]};
						if (widx == `CMB_IX_TX_PRIO)
							dat_reg[7:0] <= tx_prio_reg[i];
					end
				end
				if (widx == `CMB_IX_RX_ID_HIGH)
					dat_reg[7:0] <= rx_buf_reg.ident[`CMB_ID_HIGH_MSB:`CMB_ID_HIGH_LSB];
				if (widx == `CMB_IX_RX_ID_LOW)
					dat_reg[7:0] <= {rx_buf_reg.ident[`CMB_ID_TAIL_MSB:0],
						rx_buf_reg.rtr, rx_buf_reg.ide, 3'h0};
				if (widx >= `CMB_IX_RX_PAY0 && widx <= `CMB_IX_RX_PAY7)
					dat_reg[7:0] <= rx_buf_reg.data[{3'(widx - `CMB_IX_RX_PAY0), 3'h0} +: 8];
				if (widx == `CMB_IX_RX_LENGTH)
					dat_reg[7:0] <= {4'h0, rx_buf_reg.dlc};
				if (widx == `CMB_IX_TX_SELECT)
					dat_reg[NUM_TX-1:0] <= tx_select_reg;
				if (widx == `CMB_IX_TX_EMPTY)
					dat_reg[NUM_TX-1:0] <= tx_empty_reg;
				if (widx == `CMB_IX_RX_FULL)
					dat_reg[0] <= rx_full_reg;
				if (widx == `CMB_IX_TX_STATUS)
					dat_reg[7:0] <= {5'h0, tx_state_reg != CMB_TX_IDLE, 2'(tx_active_reg)};
			end
		end
	end

	// Transmit buffer contents, written only through the open window
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			for (int i = 0; i < NUM_TX; i++)
			begin
				tx_ident_reg[i] <= '0;
				tx_rtr_reg[i] <= 1'b0;
				tx_ide_reg[i] <= 1'b0;
				tx_dlc_reg[i] <= '0;
				tx_prio_reg[i] <= `CMB_PRIO_RESET;
				for (int b = 0; b < 8; b++)
					tx_pay_reg[i][b] <= `CMB_BYTE_RESET;
			end
		end
		else if (bus_wr && sel_ok)
		begin
			for (int i = 0; i < NUM_TX; i++)
			begin
				if (tx_select_reg[i])
				begin
					if (widx == `CMB_IX_TX_ID_HIGH)
						tx_ident_reg[i][`CMB_ID_HIGH_MSB:`CMB_ID_HIGH_LSB] <= dat_i[7:0];
					if (widx == `CMB_IX_TX_ID_LOW)
					begin
						tx_ident_reg[i][`CMB_ID_TAIL_MSB:0] <=
							dat_i[`CMB_ID_LOW_MSB:`CMB_ID_LOW_LSB];
						tx_rtr_reg[i] <= dat_i[`CMB_RTR_BIT];
						tx_ide_reg[i] <= dat_i[`CMB_IDE_BIT];
					end
					if (widx >= `CMB_IX_TX_PAY0 && widx <= `CMB_IX_TX_PAY7)
						tx_pay_reg[i][3'(widx - `CMB_IX_TX_PAY0)] <= dat_i[7:0];
					if (widx == `CMB_IX_TX_LENGTH)
						tx_dlc_reg[i] <= dat_i[`CMB_DLC_MSB:0];
					if (widx == `CMB_IX_TX_PRIO)
						tx_prio_reg[i] <= dat_i[7:0];
				end
			end
		end
	end

	// Buffer selection register
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			tx_select_reg <= '0;
		else if (bus_wr && widx == `CMB_IX_TX_SELECT)
			tx_select_reg <= sel_pick;
	end

	// Empty flags: software writes 1 to clear, a finished send sets; set wins
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			tx_empty_reg <= '1;
		else if (ce_i)
		begin
			for (int i = 0; i < NUM_TX; i++)
				if (tx_state_reg == CMB_TX_WAIT && tx_done_i && tx_active_reg == i)
					tx_empty_reg[i] <= 1'b1;
				else if (bus_wr && widx == `CMB_IX_TX_EMPTY && dat_i[i])
					tx_empty_reg[i] <= 1'b0;
		end
	end

	// Receive buffer: capture only the bytes the length code carries
	assign rx_ready_o = !rx_full_reg;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			rx_buf_reg <= '0;
		else if (ce_i && rx_valid_i && !rx_full_reg)
		begin
			rx_buf_reg.ident <= rx_frame_i.ident;
			rx_buf_reg.rtr <= rx_frame_i.rtr;
			rx_buf_reg.ide <= rx_frame_i.ide;
			rx_buf_reg.dlc <= rx_frame_i.dlc;
			for (int b = 0; b < 8; b++)
				rx_buf_reg.data[b*8 +: 8] <= (b < byte_count(rx_frame_i.rtr, rx_frame_i.dlc))
					? rx_frame_i.data[b*8 +: 8] : `CMB_BYTE_RESET;
		end
	end

	// Full flag: new frame sets, software write 1 releases; set wins
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			rx_full_reg <= 1'b0;
		else if (ce_i)
		begin
			if (rx_valid_i && !rx_full_reg)
				rx_full_reg <= 1'b1;
			else if (bus_wr && widx == `CMB_IX_RX_FULL && dat_i[0])
				rx_full_reg <= 1'b0;
		end
	end

	// Transmit sequencer
	assign tx_count = byte_count(tx_rtr_reg[tx_active_reg], tx_dlc_reg[tx_active_reg]);

	always_comb
	begin
		fifo_in = '0;
		fifo_in.ident = tx_ident_reg[tx_active_reg];
		fifo_in.rtr = tx_rtr_reg[tx_active_reg];
		fifo_in.ide = tx_ide_reg[tx_active_reg];
		fifo_in.dlc = tx_dlc_reg[tx_active_reg];
		fifo_in.is_header = (tx_state_reg == CMB_TX_HEADER);
		fifo_in.data = tx_pay_reg[tx_active_reg][tx_byte_reg[2:0]];
		fifo_in.last = (tx_state_reg == CMB_TX_HEADER) ? (tx_count == `CMB_ZERO_BYTES)
			: (tx_byte_reg == tx_count - 4'h1);
		fifo_in_valid = (tx_state_reg == CMB_TX_HEADER) || (tx_state_reg == CMB_TX_DATA);
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			tx_state_reg <= CMB_TX_IDLE;
			tx_active_reg <= '0;
			tx_byte_reg <= '0;
		end
		else if (ce_i)
		begin
			case (tx_state_reg)
				CMB_TX_IDLE:
				begin
					// Choice is frozen at the start of frame
					if (sof_req_i && win_found)
					begin
						tx_active_reg <= win_idx;
						tx_byte_reg <= '0;
						tx_state_reg <= CMB_TX_HEADER;
					end
				end
				CMB_TX_HEADER:
				begin
					if (fifo_in_ready)
						tx_state_reg <= fifo_in.last ? CMB_TX_WAIT : CMB_TX_DATA;
				end
				CMB_TX_DATA:
				begin
					if (fifo_in_ready)
					begin
						tx_byte_reg <= tx_byte_reg + 4'h1;
						if (fifo_in.last)
							tx_state_reg <= CMB_TX_WAIT;
					end
				end
				CMB_TX_WAIT:
				begin
					// A failed attempt re-runs prioritisation on the next start
					if (tx_done_i || tx_fail_i)
						tx_state_reg <= CMB_TX_IDLE;
				end
				default:
					tx_state_reg <= CMB_TX_IDLE;
			endcase
		end
	end

	// Two-entry buffer toward the bit engine; a stall downstream holds the sequencer
	assign fifo_in_ready = (fifo_cnt_reg != 2'h2);
	assign tx_valid_o = (fifo_cnt_reg != 2'h0);
	assign tx_beat_o = fifo_mem_reg[fifo_rptr_reg];

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			fifo_wptr_reg <= 1'b0;
			fifo_rptr_reg <= 1'b0;
			fifo_cnt_reg <= 2'h0;
			fifo_mem_reg[0] <= '0;
			fifo_mem_reg[1] <= '0;
		end
		else if (ce_i)
		begin
			if (fifo_in_valid && fifo_in_ready)
			begin
				fifo_mem_reg[fifo_wptr_reg] <= fifo_in;
				fifo_wptr_reg <= !fifo_wptr_reg;
			end
			if (tx_valid_o && tx_ready_i)
				fifo_rptr_reg <= !fifo_rptr_reg;
			fifo_cnt_reg <= fifo_cnt_reg + 2'(fifo_in_valid && fifo_in_ready)
				- 2'(tx_valid_o && tx_ready_i);
		end
	end

endmodule

// File: tb/cmb_checker_assertions.sv
`timescale 1ns/1ps
module cmb_checker
	import cmb_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Bus
	input wire logic ce_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic ack_o,
	// Engine side
	input wire logic sof_req_i,
	input wire logic tx_ready_i,
	input wire logic tx_valid_o,
	input wire logic tx_pending_o,
	input wire cmb_tx_beat_t tx_beat_o,
	input wire logic rx_valid_i,
	input wire logic rx_ready_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	logic hs;
	logic [3:0] n_reg;
	logic [3:0] exp_reg;
	assign hs = tx_valid_o & tx_ready_i & ce_i;
	// Counts payload beats so a frame's length can be held against its header
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			n_reg <= 4'h0;
		else if (hs && tx_beat_o.is_header)
			n_reg <= 4'h0;
		else if (hs)
			n_reg <= n_reg + 4'h1;
	end
	always_ff @(posedge clk_i)
	begin
		if (hs && tx_beat_o.is_header)
			exp_reg <= tx_beat_o.rtr ? 4'h0 : (tx_beat_o.dlc > 4'h8 ? 4'h8 : tx_beat_o.dlc);
	end
	chk_ack_latency: assert property (cyc_i && stb_i && ce_i && !ack_o |=> ack_o)
		else $error("ack late");
	chk_ack_pulse: assert property (ack_o && ce_i |=> !ack_o)
		else $error("ack too long");
	chk_valid_pending: assert property (tx_valid_o |-> tx_pending_o)
		else $error("beat without pending buffer");
	chk_beat_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_beat_o))
		else $error("beat lost in stall");
	chk_sof_start: assert property ($rose(tx_valid_o) && tx_beat_o.is_header
		|-> $past(sof_req_i, 2))
		else $error("header without start");
	chk_remote_empty: assert property (tx_valid_o && tx_beat_o.is_header && tx_beat_o.rtr
		|-> tx_beat_o.last)
		else $error("remote frame has data");
	chk_len_count: assert property (hs && !tx_beat_o.is_header && tx_beat_o.last
		|-> n_reg + 4'h1 == exp_reg)
		else $error("payload count wrong");
	chk_rx_take: assert property (rx_valid_i && rx_ready_o |=> !rx_ready_o)
		else $error("receive buffer not held");
endmodule
bind cmb_message_buffers cmb_checker u_chk (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.ce_i(ce_i),
	.cyc_i(cyc_i),
	.stb_i(stb_i),
	.ack_o(ack_o),
	.sof_req_i(sof_req_i),
	.tx_ready_i(tx_ready_i),
	.tx_valid_o(tx_valid_o),
	.tx_pending_o(tx_pending_o),
	.tx_beat_o(tx_beat_o),
	.rx_valid_i(rx_valid_i),
	.rx_ready_o(rx_ready_o)
);

// File: tb/cmb_engine_model.sv
`timescale 1ns/1ps
module cmb_engine_model
	import cmb_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Transmit beats
	input wire cmb_tx_beat_t tx_beat_i,
	input wire logic tx_valid_i,
	output logic tx_ready_o,
	output logic sof_o,
	output logic done_o,
	output logic fail_o,
	// Receive frames
	output cmb_rx_frame_t rx_frame_o,
	output logic rx_valid_o,
	input wire logic rx_ready_i
);
	logic slow = 1'b0;
	logic got;
	logic ph;
	int nb;
	cmb_tx_beat_t hdr;
	logic [7:0] pay [8];
	initial
	begin
		{sof_o, done_o, fail_o, rx_valid_o} = 4'h0;
		rx_frame_o = '0;
	end
	// Slow mode refuses every other cycle, so the buffer must hold its head
	assign tx_ready_o = !slow | ph;
	always @(posedge clk_i)
	begin
		ph <= rst_i ? 1'b0 : !ph;
		if (rst_i || sof_o)
			got <= 1'b0;
		if (tx_valid_i && tx_ready_o)
		begin
			got <= tx_beat_i.last;
			if (tx_beat_i.is_header)
				hdr <= tx_beat_i;
			if (tx_beat_i.is_header)
				nb <= 0;
			else
				nb <= nb + 1;
			if (!tx_beat_i.is_header)
				pay[nb[2:0]] <= tx_beat_i.data;
		end
	end
	task automatic frame(input logic bad);
		@(posedge clk_i);
		sof_o <= 1'b1;
		@(posedge clk_i);
		sof_o <= 1'b0;
		do @(posedge clk_i); while (got !== 1'b1);
		done_o <= !bad;
		fail_o <= bad;
		@(posedge clk_i);
		done_o <= 1'b0;
		fail_o <= 1'b0;
	endtask
	task automatic send_rx(input cmb_rx_frame_t f);
		@(posedge clk_i);
		rx_frame_o <= f;
		rx_valid_o <= 1'b1;
		do @(posedge clk_i); while (rx_ready_i !== 1'b1);
		rx_valid_o <= 1'b0;
		rx_frame_o <= ~f;
	endtask
endmodule

// File: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
	import cmb_pkg::*;
	logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, sof, done, fail, rdy, pend, tval, rxv, rxr;
	logic ce;
	logic [7:0] adr_i;
	logic [3:0] sel_i;
	logic [31:0] dat_i, dat_o, q;
	cmb_tx_beat_t beat;
	cmb_rx_frame_t rx_full_flag;
	int fail_count, n_checks;
	logic [7:0] idh [3] = '{8'h12, 8'h34, 8'h56};
	logic [7:0] idl [3] = '{8'he0, 8'h20, 8'h50};
	logic [3:0] dlc [3] = '{4'hf, 4'h1, 4'h3};
	logic [7:0] pr [3] = '{8'h05, 8'h02, 8'h02};
	initial
	begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	cmb_message_buffers dut (
		.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
		.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
		.dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.sof_req_i(sof), .tx_done_i(done), .tx_fail_i(fail), .tx_pending_o(pend),
		.tx_beat_o(beat), .tx_valid_o(tval), .tx_ready_i(rdy),
		.rx_frame_i(rx_full_flag), .rx_valid_i(rxv), .rx_ready_o(rxr)
	);
	cmb_engine_model eng (
		.clk_i(clk_i), .rst_i(rst_i), .tx_beat_i(beat), .tx_valid_i(tval),
		.tx_ready_o(rdy), .sof_o(sof), .done_o(done), .fail_o(fail),
		.rx_frame_o(rx_full_flag), .rx_valid_o(rxv), .rx_ready_i(rxr)
	);
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e)
		begin
			fail_count++;
			$display("mismatch t=%0t seen %h exp %h", $time, s, e);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= {24'h0, d};
		do @(posedge clk_i); while (ack_o !== 1'b1);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		chk(q, {24'h0, e});
	endtask
	// Header holds ident, remote and format bits and code as loaded
	task automatic tx_chk(input int b, input int n);
		chk(32'({eng.hdr.ident, eng.hdr.rtr, eng.hdr.ide, eng.hdr.dlc}),
			32'({idh[b], idl[b][7:3], dlc[b]}));
		chk(32'(eng.nb), 32'(n));
		if (n > 0)
			chk({24'h0, eng.pay[n - 1]}, 32'(16 * b + n - 1));
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge clk_i);
		fail_count++;
		conclude;
	end
	initial
	begin
		{cyc_i, stb_i, we_i} = 3'b000;
		adr_i = 8'h00;
		sel_i = 4'hf;
		ce = 1'b1;
		dat_i = '0;
		fail_count = 0;
		n_checks = 0;
		rst_i = 1'b1;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(8'h84, 8'h07);
		$display("reset test done");
		for (int i = 0; i < 3; i++)
		begin
			wr(8'h80, 8'h01 << i);
			wr(8'h00, idh[i]);
			wr(8'h04, idl[i]);
			for (int k = 0; k < 8; k++)
				wr(8'h08 + 8'(4 * k), 8'(16 * i + k));
			wr(8'h28, {4'h0, dlc[i]});
			wr(8'h2c, pr[i]);
			rd(8'h2c, pr[i]);
			rd(8'h04, idl[i]);
		end
		wr(8'h84, 8'h07);
		rd(8'h84, 8'h00);
		chk({31'h0, pend}, 32'h1);
		rd(8'h2c, 8'h00);
		rd(8'hfc, 8'h00);
		$display("load test done");
		eng.frame(1'b1);
		tx_chk(1, 1);
		eng.slow <= 1'b1;
		eng.frame(1'b0);
		tx_chk(1, 1);
		eng.frame(1'b0);
		tx_chk(2, 0);
		rd(8'h8c, 8'h02);
		eng.frame(1'b0);
		tx_chk(0, 8);
		rd(8'h84, 8'h07);
		chk({31'h0, pend}, 32'h0);
		$display("transmit test done");
		eng.send_rx({11'h5a5, 1'b0, 1'b1, 4'h2, 64'h0123_4567_89ab_cdef});
		rd(8'h40, 8'hb4);
		rd(8'h44, 8'ha8);
		rd(8'h48, 8'hef);
		rd(8'h4c, 8'hcd);
		rd(8'h50, 8'h00);
		rd(8'h68, 8'h02);
		wr(8'h88, 8'h01);
		rd(8'h88, 8'h00);
		$display("receive test done");
		@(posedge clk_i);
		ce <= 1'b0;
		fork
			rd(8'h84, 8'h07);
			begin
				repeat (4) @(posedge clk_i);
				chk({31'h0, ack_o}, 32'h0);
				ce <= 1'b1;
			end
		join
		$display("enable test done");
		conclude;
	end
endmodule
